// file: design/ssd_decoder.sv
`timescale 1ns/1ps
// How it works
// - one opcode, then zero to three argument bytes
// - idle reply bytes are all zero
// - read replies register bytes, most significant first
// - new read aborts and replaces pending reply
// - unknown opcode ignored, bad request flagged
// - 000 selector writes, 001 selector reads
// - write value arrives MSB first, then stored
// - read-only write flagged at opcode end
// - unmet condition write flagged at last byte
// - nonexistent register write flagged at opcode end
// - read value captured at decode, always readable
// - nonexistent register read flagged at opcode end
// - velocity takes 20-bit rate, top nibble ignored
// - rate clamped between lower and upper limits
// - velocity always accepted, busy low until reached
// - pulse mode sets flag, phase reads stopped
// - pulse mode left only by motion commands
// - pulse mode keeps busy, rejected while running
// - relative travel 22-bit count, rejected while running
// - phase encoding reported, status writes flagged
// - positioning opcodes decoded with act and direction
// - halt, float, flags, zero, reinit decoded; reserved rejected
// - latched flags held until flags read clears
// - status busy bit copies the busy pin one cycle later
module ssd_decoder (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  output logic [4:0] reg_sel,
  input wire logic [1:0] reg_len,
  input wire logic reg_read_only,
  input wire logic reg_cond_ok,
  input wire logic [23:0] reg_rd_data,
  output logic reg_wr,
  output logic [23:0] reg_wr_data,
  output logic motion_cmd,
  output logic [7:0] motion_code,
  output logic [23:0] motion_arg,
  input wire logic [ssd_pkg::RATE_W-1:0] upper_rate_limit,
  input wire logic [ssd_pkg::RATE_W-1:0] lower_rate_limit,
  input wire logic motor_running,
  input wire logic motion_done,
  input wire logic [1:0] engine_phase,
  input wire logic bridges_floating,
  input wire logic [ssd_pkg::NUM_FLAGS-1:0] flag_event,
  output logic busy,
  output logic pulse_mode_flag,
  output logic [1:0] motion_phase,
  output logic [15:0] status_word,
  output logic [ssd_pkg::NUM_FLAGS-1:0] latched_flags
);
  import ssd_pkg::*;

  // ------------------------------------------------------------
  // opcode classification
  // ------------------------------------------------------------
  function automatic logic is_motion(input logic [7:0] op);
    is_motion = (op[7:1] == OP_VELOCITY) || (op[7:1] == OP_REL_TRAVEL) ||
                (op == OP_ABS_SEEK) || (op[7:1] == OP_DIR_SEEK) ||
                (op == OP_SEEK_ZERO) || (op == OP_SEEK_SAVED) ||
                ((op & OP_SWITCH_MASK) == OP_SEEK_SWITCH) ||
                ((op & OP_SWITCH_MASK) == OP_BACK_OFF) ||
                (op == OP_RAMP_HALT) || (op == OP_INST_HALT) ||
                (op == OP_RAMP_FLOAT) || (op == OP_INST_FLOAT);
  endfunction

  // positioning opcodes that need the previous motion finished
  function automatic logic needs_idle(input logic [7:0] op);
    needs_idle = (op == OP_ABS_SEEK) || (op[7:1] == OP_DIR_SEEK) ||
                 (op == OP_SEEK_ZERO) || (op == OP_SEEK_SAVED);
  endfunction

  function automatic logic has_args(input logic [7:0] op);
    has_args = (op[7:1] == OP_VELOCITY) || (op[7:1] == OP_REL_TRAVEL) ||
               (op == OP_ABS_SEEK) || (op[7:1] == OP_DIR_SEEK) ||
               ((op & OP_SWITCH_MASK) == OP_SEEK_SWITCH);
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers and edge detection
  // ------------------------------------------------------------
  logic [2:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
  logic [2:0] pin_s1_next, pin_s2_next, pin_s3_next;
  logic sck_rise, sck_fall, cs_fall, cs_rise;

  always_comb begin
    pin_s1_next = {spi_mosi, spi_cs_n, spi_sck};
    pin_s2_next = pin_s1_reg;
    pin_s3_next = pin_s2_reg;
    sck_rise = pin_s2_reg[0] && !pin_s3_reg[0] && !pin_s2_reg[1];
    sck_fall = !pin_s2_reg[0] && pin_s3_reg[0] && !pin_s2_reg[1];
    cs_fall = !pin_s2_reg[1] && pin_s3_reg[1];
    cs_rise = pin_s2_reg[1] && !pin_s3_reg[1];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_s1_reg <= 3'h3;
      pin_s2_reg <= 3'h3;
      pin_s3_reg <= 3'h3;
    end else begin
      pin_s1_reg <= pin_s1_next;
      pin_s2_reg <= pin_s2_next;
      pin_s3_reg <= pin_s3_next;
    end
  end

  // ------------------------------------------------------------
  // byte shifter: sample on rising, drive on falling
  // ------------------------------------------------------------
  logic [7:0] rx_reg, rx_next, tx_reg, tx_next;
  logic [3:0] bits_reg, bits_next;
  logic miso_reg, miso_next, oe_n_reg, oe_n_next;
  logic byte_done;
  logic [23:0] resp_reg, resp_next;
  logic [1:0] resp_cnt_reg, resp_cnt_next;
  logic load_resp;
  logic [23:0] load_data;
  logic [1:0] load_len;

  always_comb begin
    rx_next = rx_reg;
    tx_next = tx_reg;
    bits_next = bits_reg;
    miso_next = miso_reg;
    oe_n_next = pin_s2_reg[1];
    resp_next = resp_reg;
    resp_cnt_next = resp_cnt_reg;
    byte_done = cs_rise && (bits_reg == 4'h8);
    if (cs_fall) begin
      bits_next = 4'h0;
      if (resp_cnt_reg != 2'h0) begin
        tx_next = resp_reg[23:16];
        resp_next = {resp_reg[15:0], ZERO_BYTE};
        resp_cnt_next = resp_cnt_reg - 2'h1;
      end else begin
        tx_next = ZERO_BYTE;
      end
      miso_next = tx_next[7];
    end else if (sck_fall && bits_reg != 4'h0) begin
      tx_next = {tx_reg[6:0], 1'b0};
      miso_next = tx_reg[6];
    end
    if (sck_rise && bits_reg != 4'h8) begin
      rx_next = {rx_reg[6:0], pin_s2_reg[2]};
      bits_next = bits_reg + 4'h1;
    end
    // a fresh response replaces whatever is still queued
    if (load_resp) begin
      resp_next = load_data;
      resp_cnt_next = load_len;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_reg <= ZERO_BYTE;
      tx_reg <= ZERO_BYTE;
      bits_reg <= 4'h0;
      miso_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      resp_reg <= 24'h000000;
      resp_cnt_reg <= 2'h0;
    end else begin
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      bits_reg <= bits_next;
      miso_reg <= miso_next;
      oe_n_reg <= oe_n_next;
      resp_reg <= resp_next;
      resp_cnt_reg <= resp_cnt_next;
    end
  end

  // ------------------------------------------------------------
  // command decoder
  // ------------------------------------------------------------
  ssd_state_e state_reg, state_next;
  logic [7:0] op_reg, op_next;
  logic [1:0] args_left_reg, args_left_next;
  logic [23:0] arg_reg, arg_next;
  logic reject_reg, reject_next;
  logic [4:0] sel_reg, sel_next;
  logic wr_reg, wr_next, mcmd_reg, mcmd_next;
  logic [23:0] wr_data_reg, wr_data_next, marg_reg, marg_next;
  logic [7:0] mcode_reg, mcode_next;
  logic busy_reg, busy_next, pulse_reg, pulse_next;
  logic [1:0] phase_reg, phase_next;
  logic [NUM_FLAGS-1:0] flags_reg, flags_next;
  logic [15:0] status_reg, status_next;
  logic bad, clear_flags, execute;
  logic [23:0] exe_arg;
  logic [RATE_W-1:0] rate;

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    args_left_next = args_left_reg;
    arg_next = arg_reg;
    reject_next = reject_reg;
    sel_next = sel_reg;
    bad = 1'b0;
    clear_flags = 1'b0;
    execute = 1'b0;
    exe_arg = arg_reg;
    load_resp = 1'b0;
    load_data = 24'h000000;
    load_len = 2'h0;
    unique case (state_reg)
      ST_OPCODE: begin
        if (byte_done) begin
          op_next = rx_reg;
          sel_next = rx_reg[4:0];
          arg_next = 24'h000000;
          reject_next = 1'b0;
          state_next = ST_DECODE;
        end
      end
      ST_DECODE: begin
        state_next = ST_OPCODE;
        if (op_reg == OP_NOP) begin
          state_next = ST_OPCODE;
        end else if (op_reg[7:5] == OP_GRP_WRITE) begin
          if (reg_len == 2'h0 || reg_read_only || sel_reg == STATUS_SEL) begin
            bad = 1'b1;
          end else begin
            args_left_next = reg_len;
            state_next = ST_ARGS;
          end
        end else if (op_reg[7:5] == OP_GRP_READ) begin
          if (sel_reg == STATUS_SEL) begin
            load_resp = 1'b1;
            load_data = {status_reg, ZERO_BYTE};
            load_len = FLAGS_LEN;
          end else if (reg_len == 2'h0) begin
            bad = 1'b1;
          end else begin
            load_resp = 1'b1;
            load_data = reg_rd_data << ((2'h3 - reg_len) * 8);
            load_len = reg_len;
          end
        end else if (op_reg == OP_FLAGS_READ) begin
          load_resp = 1'b1;
          load_data = {status_reg, ZERO_BYTE};
          load_len = FLAGS_LEN;
          clear_flags = 1'b1;
        end else if (op_reg[7:1] == OP_PULSE_MODE) begin
          bad = motor_running;
          execute = !motor_running;
        end else if (op_reg == OP_ZERO_POS) begin
          execute = 1'b1;
        end else if (op_reg == OP_FULL_REINIT) begin
          bad = !bridges_floating;
          execute = bridges_floating;
        end else if (is_motion(op_reg)) begin
          // busy-gated motion still consumes its arguments
          reject_next = ((op_reg[7:1] == OP_REL_TRAVEL) && motor_running) ||
                        (needs_idle(op_reg) && !busy_reg);
          bad = reject_next;
          if (has_args(op_reg)) begin
            args_left_next = ARG_LEN_MOTION;
            state_next = ST_ARGS;
          end else begin
            execute = !reject_next;
          end
        end else begin
          bad = 1'b1;
        end
      end
      ST_ARGS: begin
        if (byte_done) begin
          arg_next = {arg_reg[15:0], rx_reg};
          args_left_next = args_left_reg - 2'h1;
          if (args_left_reg == 2'h1) begin
            state_next = ST_OPCODE;
            exe_arg = arg_next;
            if (op_reg[7:5] == OP_GRP_WRITE && !reg_cond_ok) begin
              bad = 1'b1;
            end else begin
              execute = !reject_reg;
            end
          end
        end
      end
      default: state_next = ST_OPCODE;
    endcase
  end

  // ------------------------------------------------------------
  // dispatch, busy, pulse mode and latched flags
  // ------------------------------------------------------------
  always_comb begin
    rate = exe_arg[RATE_W-1:0];
    if (rate > upper_rate_limit) begin
      rate = upper_rate_limit;
    end else if (rate < lower_rate_limit) begin
      rate = lower_rate_limit;
    end
    wr_next = 1'b0;
    wr_data_next = wr_data_reg;
    mcmd_next = 1'b0;
    mcode_next = mcode_reg;
    marg_next = marg_reg;
    busy_next = busy_reg || motion_done;
    pulse_next = pulse_reg;
    if (execute && op_reg[7:5] == OP_GRP_WRITE) begin
      wr_next = 1'b1;
      wr_data_next = exe_arg;
    end else if (execute) begin
      mcmd_next = 1'b1;
      mcode_next = op_reg;
      marg_next = exe_arg;
      if (op_reg[7:1] == OP_VELOCITY) begin
        marg_next = {{(24 - RATE_W){1'b0}}, rate};
      end else if (op_reg[7:1] == OP_REL_TRAVEL) begin
        marg_next = {{(24 - TRAVEL_W){1'b0}}, exe_arg[TRAVEL_W-1:0]};
      end
      if (op_reg[7:1] == OP_PULSE_MODE) begin
        pulse_next = 1'b1;
      end else if (is_motion(op_reg)) begin
        busy_next = 1'b0;
        pulse_next = 1'b0;
      end
    end
    phase_next = pulse_next ? 2'h0 : engine_phase;
    flags_next = clear_flags ? '0 : flags_reg;
    flags_next = flags_next | flag_event;
    flags_next[FLAG_BAD] = flags_next[FLAG_BAD] | bad;
    status_next = {flags_reg, pulse_reg, phase_reg, busy_reg, bridges_floating, 5'h00};
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= ST_OPCODE;
      op_reg <= ZERO_BYTE;
      args_left_reg <= 2'h0;
      arg_reg <= 24'h000000;
      reject_reg <= 1'b0;
      sel_reg <= 5'h00;
      wr_reg <= 1'b0;
      wr_data_reg <= 24'h000000;
      mcmd_reg <= 1'b0;
      mcode_reg <= ZERO_BYTE;
      marg_reg <= 24'h000000;
      busy_reg <= 1'b1;
      pulse_reg <= 1'b0;
      phase_reg <= 2'h0;
      flags_reg <= '0;
      status_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      args_left_reg <= args_left_next;
      arg_reg <= arg_next;
      reject_reg <= reject_next;
      sel_reg <= sel_next;
      wr_reg <= wr_next;
      wr_data_reg <= wr_data_next;
      mcmd_reg <= mcmd_next;
      mcode_reg <= mcode_next;
      marg_reg <= marg_next;
      busy_reg <= busy_next;
      pulse_reg <= pulse_next;
      phase_reg <= phase_next;
      flags_reg <= flags_next;
      status_reg <= status_next;
    end
  end

  // ------------------------------------------------------------
  // outputs straight from flops
  // ------------------------------------------------------------
  assign spi_miso = miso_reg;
  assign spi_miso_oe_n = oe_n_reg;
  assign reg_sel = sel_reg;
  assign reg_wr = wr_reg;
  assign reg_wr_data = wr_data_reg;
  assign motion_cmd = mcmd_reg;
  assign motion_code = mcode_reg;
  assign motion_arg = marg_reg;
  assign busy = busy_reg;
  assign pulse_mode_flag = pulse_reg;
  assign motion_phase = phase_reg;
  assign status_word = status_reg;
  assign latched_flags = flags_reg;
endmodule

// file: design/ssd_pkg.sv
package ssd_pkg;
  // ------------------------------------------------------------
  // opcode encodings
  // ------------------------------------------------------------
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [2:0] OP_GRP_WRITE = 3'h0;
  localparam logic [2:0] OP_GRP_READ = 3'h1;
  localparam logic [6:0] OP_VELOCITY = 7'h28;
  localparam logic [6:0] OP_PULSE_MODE = 7'h2C;
  localparam logic [6:0] OP_REL_TRAVEL = 7'h20;
  localparam logic [7:0] OP_ABS_SEEK = 8'h60;
  localparam logic [6:0] OP_DIR_SEEK = 7'h34;
  localparam logic [7:0] OP_SEEK_ZERO = 8'h70;
  localparam logic [7:0] OP_SEEK_SAVED = 8'h78;
  localparam logic [7:0] OP_SWITCH_MASK = 8'hF6;
  localparam logic [7:0] OP_SEEK_SWITCH = 8'h82;
  localparam logic [7:0] OP_BACK_OFF = 8'h92;
  localparam logic [7:0] OP_RAMP_HALT = 8'hB0;
  localparam logic [7:0] OP_INST_HALT = 8'hB8;
  localparam logic [7:0] OP_RAMP_FLOAT = 8'hA0;
  localparam logic [7:0] OP_INST_FLOAT = 8'hA8;
  localparam logic [7:0] OP_FLAGS_READ = 8'hD0;
  localparam logic [7:0] OP_ZERO_POS = 8'hD8;
  localparam logic [7:0] OP_FULL_REINIT = 8'hC0;

  // ------------------------------------------------------------
  // lengths, selectors, status layout
  // ------------------------------------------------------------
  localparam logic [1:0] ARG_LEN_MOTION = 2'h3;
  localparam logic [1:0] FLAGS_LEN = 2'h2;
  localparam logic [4:0] STATUS_SEL = 5'h19;
  localparam int RATE_W = 20;
  localparam int TRAVEL_W = 22;
  localparam int FLAG_UV = 0;
  localparam int FLAG_OC = 1;
  localparam int FLAG_STALL = 2;
  localparam int FLAG_THERM = 3;
  localparam int FLAG_BAD = 4;
  localparam int FLAG_SW = 5;
  localparam int NUM_FLAGS = 6;
  localparam logic [2:0] BIT_CNT_FULL = 3'h7;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // decoder states
  typedef enum logic [2:0] {
    ST_OPCODE = 3'b001,
    ST_DECODE = 3'b010,
    ST_ARGS = 3'b100
  } ssd_state_e;
endpackage

// file: verification/ssd_checker_assertions.sv
`timescale 1ns/1ps
module ssd_checker
  import ssd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic spi_cs_n,
  input wire logic spi_miso_oe_n,
  input wire logic reg_wr,
  input wire logic motion_cmd,
  input wire logic [7:0] motion_code,
  input wire logic [23:0] motion_arg,
  input wire logic [ssd_pkg::RATE_W-1:0] upper_rate_limit,
  input wire logic [ssd_pkg::RATE_W-1:0] lower_rate_limit,
  input wire logic motion_done,
  input wire logic [1:0] engine_phase,
  input wire logic [ssd_pkg::NUM_FLAGS-1:0] flag_event,
  input wire logic busy,
  input wire logic pulse_mode_flag,
  input wire logic [1:0] motion_phase,
  input wire logic [15:0] status_word,
  input wire logic [ssd_pkg::NUM_FLAGS-1:0] latched_flags
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // velocity dispatch seen at the port
  sequence vel_seq;
    motion_cmd && motion_code[7:1] == OP_VELOCITY;
  endsequence

  wr_pulse_a:
    assert property (reg_wr |=> !reg_wr) else $error("register write strobe too long");
  cmd_pulse_a:
    assert property (motion_cmd |=> !motion_cmd) else $error("dispatch strobe too long");
  rate_clamp_a:
    assert property (vel_seq |-> motion_arg[RATE_W-1:0] <= upper_rate_limit
      && motion_arg[RATE_W-1:0] >= lower_rate_limit) else $error("rate outside limits");
  vel_busy_a:
    assert property (vel_seq |-> !busy && !pulse_mode_flag) else $error("velocity left busy or pulse mode");
  busy_cause_a:
    assert property ($fell(busy) |-> motion_cmd) else $error("busy fell without dispatch");
  busy_release_a:
    assert property (motion_done |=> busy || motion_cmd) else $error("busy not released");
  status_busy_a:
    assert property ($stable(busy) && !$past(rst) |-> status_word[6] == busy) else $error("status busy differs");
  pulse_stop_a:
    assert property (pulse_mode_flag && $past(pulse_mode_flag) |-> motion_phase == 2'b00)
      else $error("phase not stopped in pulse mode");
  phase_follow_a:
    assert property (!pulse_mode_flag && !$past(pulse_mode_flag) && !$past(rst)
      |-> motion_phase == $past(engine_phase)) else $error("phase does not follow engine");
  flag_latch_a:
    assert property (flag_event != 0 |=> (latched_flags & $past(flag_event)) == $past(flag_event))
      else $error("flag event not latched");
  oe_idle_a:
    assert property (spi_cs_n [*5] |-> spi_miso_oe_n) else $error("data out driven while deselected");

  // main scenarios reached
  vel_c: cover property (vel_seq);
  wr_c: cover property (reg_wr);
  pulse_c: cover property ($rose(pulse_mode_flag));
  bad_c: cover property ($rose(latched_flags[FLAG_BAD]));
endmodule

// file: verification/ssd_host.sv
`timescale 1ns/1ps
module ssd_host (
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  // idle: clock high, deselected
  initial begin
    spi_sck = 1'b1;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b1;
  end

  // one byte per frame, msb first, mode 3, 320 ns clock
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    #13;
    spi_cs_n = 1'b0;
    #160;
    for (int i = 7; i >= 0; i--) begin
      spi_sck = 1'b0;
      spi_mosi = tx[i];
      #160;
      spi_sck = 1'b1;
      rx[i] = spi_miso;
      #160;
    end
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi; // released line shows no stale bit
    #480;
  endtask
endmodule

// file: verification/tb_stepper_spi_command_decoder.sv
`timescale 1ns/1ps
module tb_stepper_spi_command_decoder;
  import ssd_pkg::*;
  // ------------------------------------------------------------
  // signals and helpers
  // ------------------------------------------------------------
  logic clk_sys, rst, spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n, reg_read_only, reg_cond_ok;
  logic reg_wr, motion_cmd, motor_running, motion_done, bridges_floating, busy, pulse_mode_flag, pm;
  logic [1:0] reg_len, engine_phase, motion_phase;
  logic [4:0] reg_sel;
  logic [5:0] flag_event, latched_flags;
  logic [7:0] motion_code, rx;
  logic [15:0] status_word;
  logic [19:0] upper_rate_limit, lower_rate_limit;
  logic [23:0] reg_rd_data, reg_wr_data, motion_arg, v;
  logic [31:0] seed = 32'h000003F2;
  int err_total, checks, wr_n, mc_n, cyc, n;
  logic [7:0] ops [10] = '{8'h70, 8'h78, 8'hB0, 8'hB8, 8'hA0, 8'hA8, 8'h9B, 8'h60, 8'h69, 8'h8B};
  logic [7:0] rop [6] = '{8'hEB, 8'hF8, 8'h03, 8'h1F, 8'h3F, 8'h19};
  logic [1:0] rlen [6] = '{2'h3, 2'h3, 2'h2, 2'h0, 2'h0, 2'h2};
  logic rro [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

  ssd_decoder dut (.clk_sys(clk_sys), .rst(rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n), .reg_sel(reg_sel), .reg_len(reg_len),
    .reg_read_only(reg_read_only), .reg_cond_ok(reg_cond_ok), .reg_rd_data(reg_rd_data), .reg_wr(reg_wr),
    .reg_wr_data(reg_wr_data), .motion_cmd(motion_cmd), .motion_code(motion_code), .motion_arg(motion_arg),
    .upper_rate_limit(upper_rate_limit), .lower_rate_limit(lower_rate_limit), .motor_running(motor_running),
    .motion_done(motion_done), .engine_phase(engine_phase), .bridges_floating(bridges_floating),
    .flag_event(flag_event), .busy(busy), .pulse_mode_flag(pulse_mode_flag), .motion_phase(motion_phase),
    .status_word(status_word), .latched_flags(latched_flags));
  // a released data line reads inverted, so a stale bit cannot pass
  ssd_host host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso_oe_n ? ~spi_miso : spi_miso));

  function automatic logic [23:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[23:0];
  endfunction
  function automatic logic [19:0] clamp(input logic [23:0] r);
    if (r[19:0] > upper_rate_limit) return upper_rate_limit;
    if (r[19:0] < lower_rate_limit) return lower_rate_limit;
    return r[19:0];
  endfunction
  function automatic logic [15:0] stat(input logic [5:0] f);
    return {f, pm, pm ? 2'b00 : engine_phase, 1'b1, bridges_floating, 5'h00};
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic [7:0] e);
    @(negedge clk_sys);
    host.xfer(b, rx);
    @(negedge clk_sys);
    chk(rx, e);
  endtask
  task automatic clear_flags(input logic [5:0] f);
    logic [15:0] s;
    s = stat(f);
    chk(latched_flags, f);
    send(OP_FLAGS_READ, 8'h00);
    send(8'h00, s[15:8]);
    send(8'h00, s[7:0]);
    chk(latched_flags, 6'h00);
  endtask
  task automatic finish_motion();
    motion_done = 1'b1;
    @(negedge clk_sys);
    motion_done = 1'b0;
    @(negedge clk_sys);
    chk(busy, 1'b1);
  endtask
  task automatic close_out();
    $display("mismatches=%0d comparisons=%0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // strobe counters and run ceiling
  always @(posedge clk_sys) begin
    cyc++;
    if (reg_wr === 1'b1)
      wr_n++;
    if (motion_cmd === 1'b1)
      mc_n++;
    if (cyc == 40000) begin
      err_total++;
      close_out();
    end
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {reg_read_only, motor_running, motion_done, bridges_floating, pm} = 5'h00;
    reg_cond_ok = 1'b1;
    reg_len = 2'h3;
    reg_rd_data = 24'h000000;
    engine_phase = 2'h0;
    flag_event = 6'h00;
    upper_rate_limit = 20'h80000;
    lower_rate_limit = 20'h00100;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk({busy, spi_miso_oe_n, status_word, latched_flags}, {2'b11, stat(6'h00), 6'h00});
    v = rnd();
    send(8'h05, 8'h00);
    for (int k = 2; k >= 0; k--)
      send(v[8*k+:8], 8'h00);
    chk({reg_sel, reg_wr_data, 8'(wr_n)}, {5'h05, v, 8'h01});
    reg_len = 2'h2;
    reg_cond_ok = 1'b0;
    send(8'h07, 8'h00);
    send(8'hAB, 8'h00);
    send(8'hCD, 8'h00);
    reg_cond_ok = 1'b1;
    clear_flags(6'h10);
    for (int i = 0; i < 6; i++) begin
      reg_len = rlen[i];
      reg_read_only = rro[i];
      send(rop[i], 8'h00);
      clear_flags(6'h10);
    end
    reg_read_only = 1'b0;
    chk(24'(wr_n), 24'h000001);
    reg_len = 2'h3;
    v = rnd();
    reg_rd_data = v;
    send(8'h25, 8'h00);
    reg_rd_data = ~v;
    send(8'h00, v[23:16]);
    reg_len = 2'h2;
    reg_rd_data = rnd();
    send(8'h26, v[15:8]);
    v = reg_rd_data;
    reg_rd_data = ~v;
    send(8'h00, v[15:8]);
    send(8'h00, v[7:0]);
    send(8'h00, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 24'hFFFFFF : (i == 1) ? 24'h000010 : (i == 2) ? 24'hF12345 : rnd();
      motor_running = i[0];
      n = mc_n;
      send({OP_VELOCITY, i[0]}, 8'h00);
      for (int k = 2; k >= 0; k--)
        send(v[8*k+:8], 8'h00);
      chk(24'(mc_n - n), 24'h000001);
      chk(motion_code, {OP_VELOCITY, i[0]});
      chk(motion_arg, {4'h0, clamp(v)});
      chk(busy, 1'b0);
      if (i != 1)
        finish_motion();
    end
    motor_running = 1'b0;
    v = rnd();
    flag_event = v[5:0] | 6'h01;
    @(negedge clk_sys);
    flag_event = 6'h00;
    clear_flags(v[5:0] | 6'h01);
    engine_phase = 2'h3;
    send({OP_PULSE_MODE, 1'b1}, 8'h00);
    pm = 1'b1;
    chk({pulse_mode_flag, busy}, 2'b11);
    bridges_floating = 1'b1;
    send({OP_PULSE_MODE, 1'b0}, 8'h00);
    chk({pulse_mode_flag, motion_phase}, 3'b100);
    motor_running = 1'b1;
    send({OP_PULSE_MODE, 1'b1}, 8'h00);
    clear_flags(6'h10);
    n = mc_n;
    send({OP_REL_TRAVEL, 1'b1}, 8'h00);
    repeat (3) send(OP_FLAGS_READ, 8'h00);
    chk(24'(mc_n - n), 24'h000000);
    clear_flags(6'h10);
    motor_running = 1'b0;
    v = rnd();
    send({OP_REL_TRAVEL, 1'b0}, 8'h00);
    for (int k = 2; k >= 0; k--)
      send(v[8*k+:8], 8'h00);
    pm = 1'b0;
    chk(motion_arg, {2'b00, v[21:0]});
    chk({pulse_mode_flag, busy}, 2'b00);
    finish_motion();
    for (int i = 0; i < 4; i++) begin
      engine_phase = i[1:0];
      repeat (2) @(negedge clk_sys);
      chk(motion_phase, i[1:0]);
    end
    for (int i = 0; i < 10; i++) begin
      n = mc_n;
      send(ops[i], 8'h00);
      if (i > 6)
        repeat (3) send(8'h00, 8'h00);
      chk({8'(mc_n - n), motion_code}, {8'h01, ops[i]});
      finish_motion();
    end
    send(OP_RAMP_HALT, 8'h00);
    n = mc_n;
    send(OP_SEEK_ZERO, 8'h00);
    chk(24'(mc_n - n), 24'h000000);
    finish_motion();
    n = mc_n;
    bridges_floating = 1'b1;
    send(OP_ZERO_POS, 8'h00);
    send(OP_FULL_REINIT, 8'h00);
    chk({8'(mc_n - n), motion_code, busy}, {8'h02, OP_FULL_REINIT, 1'b1});
    bridges_floating = 1'b0;
    send(OP_FULL_REINIT, 8'h00);
    v = {stat(6'h10), ZERO_BYTE};
    send({OP_GRP_READ, STATUS_SEL}, 8'h00);
    send(8'h00, v[23:16]);
    send(8'h00, v[15:8]);
    clear_flags(6'h10);
    close_out();
  end
endmodule

bind ssd_decoder ssd_checker chk_i (.clk_sys(clk_sys), .rst(rst), .spi_cs_n(spi_cs_n),
  .spi_miso_oe_n(spi_miso_oe_n), .reg_wr(reg_wr), .motion_cmd(motion_cmd), .motion_code(motion_code),
  .motion_arg(motion_arg), .upper_rate_limit(upper_rate_limit), .lower_rate_limit(lower_rate_limit),
  .motion_done(motion_done), .engine_phase(engine_phase), .flag_event(flag_event), .busy(busy),
  .pulse_mode_flag(pulse_mode_flag), .motion_phase(motion_phase), .status_word(status_word),
  .latched_flags(latched_flags));
